// ==== include/svtt_pkg.sv ====
package svtt_pkg;
  // program cycle and clock
  localparam int CLK_HZ = 20000000;
  localparam int TICK_US = 5000;
  localparam int TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
  localparam int MAX_TIME_S = 1800;
  localparam int MAX_TICKS = MAX_TIME_S * (1000000 / TICK_US);
  localparam int TDIAL_UNIT_US = 10000;
  localparam int K_TICKS = TDIAL_UNIT_US / TICK_US;
  // fixed point
  localparam int Q_SH = 16;
  localparam logic [32:0] Q_ONE = 33'h000010000;
  localparam int PCT = 100;
  localparam int HYST_OVER_PCT = 97;
  localparam int HYST_UNDER_PCT = 103;
  localparam int USET_FULL = 10000;
  // register offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_USET = 8'h04;
  localparam logic [7:0] ADR_UNDER_BLOCK_LEVEL = 8'h08;
  localparam logic [7:0] ADR_DT = 8'h0C;
  localparam logic [7:0] ADR_REL = 8'h10;
  localparam logic [7:0] ADR_TDIAL = 8'h14;
  localparam logic [7:0] ADR_MULT = 8'h18;
  localparam logic [7:0] ADR_VT = 8'h1C;
  localparam logic [7:0] ADR_STAT = 8'h20;
  localparam logic [7:0] ADR_EXP = 8'h24;
  localparam logic [7:0] ADR_REMAIN = 8'h28;
  localparam logic [7:0] ADR_RATIO = 8'h2C;
  localparam logic [7:0] ADR_PRI = 8'h30;
  localparam logic [7:0] ADR_BEVT = 8'h34;
  localparam logic [7:0] ADR_BTS = 8'h38;
  // control field positions
  localparam int CTRL_UNDER = 0;
  localparam int CTRL_DLY = 1;
  localparam int CTRL_RELEN = 3;
  localparam int CTRL_CALCRST = 4;
  localparam int CTRL_CONT = 5;
  localparam int CTRL_MODE = 8;
  // codes
  localparam logic [1:0] DLY_FIXED = 2'h1;
  localparam logic [1:0] DLY_INVERSE = 2'h2;
  localparam logic [2:0] BEH_ON = 3'h1;
  localparam logic [2:0] BEH_BLOCKED = 3'h2;
  localparam logic [2:0] BEH_TEST = 3'h3;
  localparam logic [2:0] BEH_TESTBLK = 3'h4;
  localparam logic [2:0] BEH_OFF = 3'h5;
  // reset values
  localparam logic [15:0] USET_RST = 16'h2904;
  localparam logic [15:0] UNDER_BLOCK_LEVEL_RST = 16'h01F4;
  localparam logic [18:0] DT_RST = 19'h00008;
  localparam logic [14:0] REL_RST = 15'h000C;
  localparam logic [15:0] TDIAL_RST = 16'h0005;
  localparam logic [15:0] MULT_RST = 16'h0064;
  localparam logic [19:0] VT_RST = 20'h003E8;
  typedef enum logic [1:0] {CALC_IDLE, CALC_RATIO, CALC_POW, CALC_TIME} svtt_calc_t;
endpackage

// ==== include/svtt_calc_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface svtt_calc_if;
  logic start;
  logic done;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] res;
  modport req (output start, output opa, output opb, input done, input res);
  modport srv (input start, input opa, input opb, output done, output res);
endinterface
`default_nettype wire

// ==== verilog/svtt_div.sv ====
`timescale 1ns/100ps
`default_nettype none
module svtt_div (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // operation: res = opa / opb
  svtt_calc_if.srv calc
);
  logic busy_q;
  logic [5:0] cnt_q;
  logic [31:0] quo_q;
  logic [31:0] rem_q;
  logic [31:0] den_q;
  logic [32:0] trial;
  logic ge;

  always_comb begin
    trial = {rem_q, quo_q[31]};
    ge = trial >= {1'b0, den_q};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= 6'h00;
      quo_q <= 32'h0;
      rem_q <= 32'h0;
      den_q <= 32'h0;
      calc.done <= 1'b0;
      calc.res <= 32'h0;
    end else begin
      calc.done <= 1'b0;
      if (calc.start && !busy_q) begin
        if (calc.opb == 32'h0) begin
          calc.res <= 32'hFFFFFFFF;
          calc.done <= 1'b1;
        end else begin
          busy_q <= 1'b1;
          cnt_q <= 6'h20;
          quo_q <= calc.opa;
          rem_q <= 32'h0;
          den_q <= calc.opb;
        end
      end else if (busy_q) begin
        rem_q <= ge ? 32'(trial - {1'b0, den_q}) : trial[31:0];
        quo_q <= {quo_q[30:0], ge};
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          calc.done <= 1'b1;
          calc.res <= {quo_q[30:0], ge};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/svtt_pow.sv ====
`timescale 1ns/100ps
`default_nettype none
module svtt_pow (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // operation: res = opa ^ (opb / 100), opa and res in q16
  svtt_calc_if.srv calc
);
  logic busy_q;
  logic [4:0] n_q;
  logic [6:0] f_q;
  logic [31:0] r_q;
  logic [31:0] acc_q;
  logic [63:0] sq;
  logic signed [79:0] frac;
  logic signed [79:0] fin;

  always_comb begin
    sq = ({32'h0, acc_q} * {32'h0, r_q}) >> svtt_pkg::Q_SH;
    frac = $signed({48'h0, acc_q}) * ($signed({48'h0, r_q}) - $signed({47'h0, svtt_pkg::Q_ONE}));
    frac = (frac * $signed({73'h0, f_q})) / svtt_pkg::PCT;
    fin = (frac >>> svtt_pkg::Q_SH) + $signed({48'h0, acc_q});
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      n_q <= 5'h00;
      f_q <= 7'h00;
      r_q <= 32'h0;
      acc_q <= 32'h0;
      calc.done <= 1'b0;
      calc.res <= 32'h0;
    end else begin
      calc.done <= 1'b0;
      if (calc.start && !busy_q) begin
        busy_q <= 1'b1;
        n_q <= 5'(calc.opb / svtt_pkg::PCT);
        f_q <= 7'(calc.opb % svtt_pkg::PCT);
        r_q <= calc.opa;
        acc_q <= svtt_pkg::Q_ONE[31:0];
      end else if (busy_q && n_q != 5'h00) begin
        acc_q <= (sq > 64'h7FFFFFFF) ? 32'h7FFFFFFF : sq[31:0];
        n_q <= n_q - 5'h01;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        calc.done <= 1'b1;
        if (fin < 0)
          calc.res <= 32'h0;
        else if (fin > 80'sh7FFFFFFF)
          calc.res <= 32'h7FFFFFFF;
        else
          calc.res <= fin[31:0];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/svtt_seq_voltage_stage.sv ====
`timescale 1ns/100ps
`default_nettype none
module svtt_seq_voltage_stage #(
  parameter int TICK_CYC = svtt_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // measurement and blocking matrix
  input wire logic [15:0] measured_voltage_i,
  input wire logic [15:0] line_min_voltage_i,
  input wire logic block_i,
  // stage outputs
  output logic start_o,
  output logic trip_o,
  output logic blocked_o,
  // blocking event
  output logic blk_evt_o,
  output logic hmi_note_o,
  output logic [15:0] blk_evt_volt_o,
  output logic blk_evt_under_o,
  output logic [31:0] blk_evt_ts_o
);
  svtt_calc_if div_if ();
  svtt_calc_if pow_if ();

  svtt_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .calc(div_if.srv)
  );

  svtt_pow u_pow (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .calc(pow_if.srv)
  );

  // settings
  logic under_q, rel_en_q, calc_rst_q, cont_q;
  logic [1:0] dly_type_q;
  logic [2:0] mode_q;
  logic [15:0] uset_q, under_block_level_q, tdial_q, mult_q;
  logic [18:0] dt_q;
  logic [14:0] rel_dly_q;
  logic [19:0] vt_q;
  // state
  logic ack_q;
  logic [31:0] dat_q;
  logic [16:0] tcnt_q;
  logic tick_q, eval_q;
  logic blk_s_q, pick_q, inhib_q, ep_q, notrip_q;
  logic start_q, trip_q, blocked_q, evt_q;
  logic [18:0] op_q, inverse_delay_mode_q, exp_q;
  logic [14:0] rel_q;
  logic [31:0] remain_q, ratio_q, ratio_pct_q, pri_q, ts_q, bts_q;
  logic [15:0] bvolt_q;
  logic bunder_q;
  logic [2:0] beh_q;
  svtt_pkg::svtt_calc_t calc_q;
  // combinational
  logic acc, wr;
  logic [31:0] rdata, wm;
  logic [18:0] target, op_nx;
  logic signed [33:0] denom;
  logic is_inv, off, forced_blk, blk_now, ep;
  logic [23:0] um_pct, set_lo, set_hi;

  always_comb begin
    acc = wb_cyc_i & wb_stb_i & ~ack_q;
    wr = acc & wb_we_i;
    is_inv = dly_type_q == svtt_pkg::DLY_INVERSE;
    off = mode_q == svtt_pkg::BEH_OFF;
    forced_blk = mode_q == svtt_pkg::BEH_BLOCKED || mode_q == svtt_pkg::BEH_TESTBLK;
    blk_now = block_i | forced_blk;
    ep = pick_q & ~blk_s_q & ~off;
    target = is_inv ? inverse_delay_mode_q : dt_q;
    op_nx = (op_q >= 19'(svtt_pkg::MAX_TICKS)) ? op_q : op_q + 19'h00001;
    denom = under_q ? $signed({1'b0, svtt_pkg::Q_ONE}) - $signed({2'b00, pow_if.res})
                    : $signed({2'b00, pow_if.res}) - $signed({1'b0, svtt_pkg::Q_ONE});
    um_pct = 24'(measured_voltage_i) * 24'(svtt_pkg::PCT);
    set_lo = 24'(uset_q) * 24'(svtt_pkg::HYST_OVER_PCT);
    set_hi = 24'(uset_q) * 24'(svtt_pkg::HYST_UNDER_PCT);
  end

  // register read mux
  always_comb begin
    rdata = 32'h0;
    if (wb_adr_i == svtt_pkg::ADR_CTRL) begin
      rdata[svtt_pkg::CTRL_UNDER] = under_q;
      rdata[svtt_pkg::CTRL_DLY +: 2] = dly_type_q;
      rdata[svtt_pkg::CTRL_RELEN] = rel_en_q;
      rdata[svtt_pkg::CTRL_CALCRST] = calc_rst_q;
      rdata[svtt_pkg::CTRL_CONT] = cont_q;
      rdata[svtt_pkg::CTRL_MODE +: 3] = mode_q;
    end else if (wb_adr_i == svtt_pkg::ADR_USET) begin
      rdata = {16'h0, uset_q};
    end else if (wb_adr_i == svtt_pkg::ADR_UNDER_BLOCK_LEVEL) begin
      rdata = {16'h0, under_block_level_q};
    end else if (wb_adr_i == svtt_pkg::ADR_DT) begin
      rdata = {13'h0, dt_q};
    end else if (wb_adr_i == svtt_pkg::ADR_REL) begin
      rdata = {17'h0, rel_dly_q};
    end else if (wb_adr_i == svtt_pkg::ADR_TDIAL) begin
      rdata = {16'h0, tdial_q};
    end else if (wb_adr_i == svtt_pkg::ADR_MULT) begin
      rdata = {16'h0, mult_q};
    end else if (wb_adr_i == svtt_pkg::ADR_VT) begin
      rdata = {12'h0, vt_q};
    end else if (wb_adr_i == svtt_pkg::ADR_STAT) begin
      rdata = {21'h0, beh_q, 3'h0, notrip_q, inhib_q, blocked_q, trip_q, start_q};
    end else if (wb_adr_i == svtt_pkg::ADR_EXP) begin
      rdata = {13'h0, exp_q};
    end else if (wb_adr_i == svtt_pkg::ADR_REMAIN) begin
      rdata = remain_q;
    end else if (wb_adr_i == svtt_pkg::ADR_RATIO) begin
      rdata = ratio_pct_q;
    end else if (wb_adr_i == svtt_pkg::ADR_PRI) begin
      rdata = pri_q;
    end else if (wb_adr_i == svtt_pkg::ADR_BEVT) begin
      rdata = {15'h0, bunder_q, bvolt_q};
    end else if (wb_adr_i == svtt_pkg::ADR_BTS) begin
      rdata = bts_q;
    end
    for (int i = 0; i < 4; i++) begin
      wm[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : rdata[i*8 +: 8];
    end
  end

  // bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= acc;
      if (acc)
        dat_q <= rdata;
    end
  end

  // setting registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      under_q <= 1'b0;
      dly_type_q <= svtt_pkg::DLY_FIXED;
      rel_en_q <= 1'b1;
      calc_rst_q <= 1'b1;
      cont_q <= 1'b0;
      mode_q <= svtt_pkg::BEH_ON;
      uset_q <= svtt_pkg::USET_RST;
      under_block_level_q <= svtt_pkg::UNDER_BLOCK_LEVEL_RST;
      dt_q <= svtt_pkg::DT_RST;
      rel_dly_q <= svtt_pkg::REL_RST;
      tdial_q <= svtt_pkg::TDIAL_RST;
      mult_q <= svtt_pkg::MULT_RST;
      vt_q <= svtt_pkg::VT_RST;
    end else if (wr) begin
      if (wb_adr_i == svtt_pkg::ADR_CTRL) begin
        under_q <= wm[svtt_pkg::CTRL_UNDER];
        if (wm[svtt_pkg::CTRL_DLY +: 2] == svtt_pkg::DLY_FIXED ||
            wm[svtt_pkg::CTRL_DLY +: 2] == svtt_pkg::DLY_INVERSE)
          dly_type_q <= wm[svtt_pkg::CTRL_DLY +: 2];
        rel_en_q <= wm[svtt_pkg::CTRL_RELEN];
        calc_rst_q <= wm[svtt_pkg::CTRL_CALCRST];
        cont_q <= wm[svtt_pkg::CTRL_CONT];
        if (wm[svtt_pkg::CTRL_MODE +: 3] >= svtt_pkg::BEH_ON &&
            wm[svtt_pkg::CTRL_MODE +: 3] <= svtt_pkg::BEH_OFF)
          mode_q <= wm[svtt_pkg::CTRL_MODE +: 3];
      end else if (wb_adr_i == svtt_pkg::ADR_USET) begin
        uset_q <= wm[15:0];
      end else if (wb_adr_i == svtt_pkg::ADR_UNDER_BLOCK_LEVEL) begin
        under_block_level_q <= wm[15:0];
      end else if (wb_adr_i == svtt_pkg::ADR_DT) begin
        dt_q <= (wm > 32'(svtt_pkg::MAX_TICKS)) ? 19'(svtt_pkg::MAX_TICKS) : wm[18:0];
      end else if (wb_adr_i == svtt_pkg::ADR_REL) begin
        rel_dly_q <= wm[14:0];
      end else if (wb_adr_i == svtt_pkg::ADR_TDIAL) begin
        tdial_q <= wm[15:0];
      end else if (wb_adr_i == svtt_pkg::ADR_MULT) begin
        mult_q <= wm[15:0];
      end else if (wb_adr_i == svtt_pkg::ADR_VT) begin
        vt_q <= wm[19:0];
      end
    end
  end

  // program cycle tick; evaluation runs one clock after sampling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcnt_q <= 17'h00000;
      tick_q <= 1'b0;
      eval_q <= 1'b0;
    end else begin
      tick_q <= tcnt_q == 17'(TICK_CYC - 1);
      tcnt_q <= (tcnt_q == 17'(TICK_CYC - 1)) ? 17'h00000 : tcnt_q + 17'h00001;
      eval_q <= tick_q;
    end
  end

  // block sample, pick-up with hysteresis, under-voltage inhibit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_s_q <= 1'b0;
      pick_q <= 1'b0;
      inhib_q <= 1'b0;
    end else if (tick_q) begin
      blk_s_q <= blk_now;
      if (!under_q) begin
        if (measured_voltage_i > uset_q)
          pick_q <= 1'b1;
        else if (um_pct < set_lo)
          pick_q <= 1'b0;
      end else begin
        if (measured_voltage_i < uset_q)
          pick_q <= 1'b1;
        else if (um_pct > set_hi)
          pick_q <= 1'b0;
      end
      if (!under_q || under_block_level_q == 16'h0000)
        inhib_q <= 1'b0;
      else if (measured_voltage_i < under_block_level_q)
        inhib_q <= 1'b1;
      else if (line_min_voltage_i > uset_q)
        inhib_q <= 1'b0;
    end
  end

  // inverse time calculation sequence, one pass per tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      calc_q <= svtt_pkg::CALC_IDLE;
      div_if.start <= 1'b0;
      div_if.opa <= 32'h0;
      div_if.opb <= 32'h0;
      pow_if.start <= 1'b0;
      pow_if.opa <= 32'h0;
      pow_if.opb <= 32'h0;
      ratio_q <= 32'h0;
      inverse_delay_mode_q <= 19'(svtt_pkg::MAX_TICKS);
      notrip_q <= 1'b1;
    end else begin
      div_if.start <= 1'b0;
      pow_if.start <= 1'b0;
      case (calc_q)
        svtt_pkg::CALC_IDLE: begin
          if (tick_q) begin
            div_if.opa <= {measured_voltage_i, 16'h0000};
            div_if.opb <= {16'h0000, uset_q};
            div_if.start <= 1'b1;
            calc_q <= svtt_pkg::CALC_RATIO;
          end
        end
        svtt_pkg::CALC_RATIO: begin
          if (div_if.done) begin
            ratio_q <= div_if.res;
            pow_if.opa <= div_if.res;
            pow_if.opb <= {16'h0000, mult_q};
            pow_if.start <= 1'b1;
            calc_q <= svtt_pkg::CALC_POW;
          end
        end
        svtt_pkg::CALC_POW: begin
          if (pow_if.done) begin
            if (denom <= 0) begin
              notrip_q <= 1'b1;
              inverse_delay_mode_q <= 19'(svtt_pkg::MAX_TICKS);
              calc_q <= svtt_pkg::CALC_IDLE;
            end else begin
              div_if.opa <= 32'(tdial_q) * 32'(svtt_pkg::K_TICKS) << svtt_pkg::Q_SH;
              div_if.opb <= denom[31:0];
              div_if.start <= 1'b1;
              calc_q <= svtt_pkg::CALC_TIME;
            end
          end
        end
        svtt_pkg::CALC_TIME: begin
          if (div_if.done) begin
            notrip_q <= 1'b0;
            inverse_delay_mode_q <= (div_if.res > 32'(svtt_pkg::MAX_TICKS)) ?
                      19'(svtt_pkg::MAX_TICKS) : div_if.res[18:0];
            calc_q <= svtt_pkg::CALC_IDLE;
          end
        end
        default: calc_q <= svtt_pkg::CALC_IDLE;
      endcase
    end
  end

  // start, trip, blocked and operate/release timers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
      trip_q <= 1'b0;
      blocked_q <= 1'b0;
      ep_q <= 1'b0;
      op_q <= 19'h00000;
      rel_q <= 15'h0000;
    end else if (eval_q) begin
      ep_q <= ep;
      if (off) begin
        start_q <= 1'b0;
        trip_q <= 1'b0;
        blocked_q <= 1'b0;
        op_q <= 19'h00000;
        rel_q <= 15'h0000;
      end else begin
        blocked_q <= pick_q & blk_s_q;
        if (ep) begin
          start_q <= 1'b1;
          rel_q <= 15'h0000;
          op_q <= op_nx;
          trip_q <= ~inhib_q & ~(is_inv & notrip_q) &
                    (target == 19'h00000 || op_nx >= target);
        end else begin
          trip_q <= 1'b0;
          if (ep_q) begin
            rel_q <= rel_dly_q;
            start_q <= rel_en_q & ~blk_s_q & (rel_dly_q != 15'h0000);
            if (!calc_rst_q || rel_dly_q == 15'h0000)
              op_q <= 19'h00000;
          end else if (rel_q != 15'h0000) begin
            rel_q <= rel_q - 15'h0001;
            if (cont_q)
              op_q <= op_nx;
            if (rel_q == 15'h0001 || blk_s_q)
              start_q <= 1'b0;
            if (rel_q == 15'h0001 && calc_rst_q)
              op_q <= 19'h00000;
          end else begin
            start_q <= 1'b0;
          end
        end
      end
    end
  end

  // read-only values and blocking event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exp_q <= svtt_pkg::DT_RST;
      remain_q <= 32'h0;
      ratio_pct_q <= 32'h0;
      pri_q <= 32'h0;
      beh_q <= svtt_pkg::BEH_ON;
      ts_q <= 32'h0;
      evt_q <= 1'b0;
      bvolt_q <= 16'h0000;
      bunder_q <= 1'b0;
      bts_q <= 32'h0;
    end else begin
      evt_q <= 1'b0;
      if (eval_q) begin
        ts_q <= ts_q + 32'h1;
        exp_q <= (is_inv && notrip_q) ? 19'(svtt_pkg::MAX_TICKS) : target;
        remain_q <= ep ? 32'($signed({1'b0, target}) - $signed({1'b0, op_nx})) : 32'h0;
        ratio_pct_q <= 32'((40'(ratio_q) * 40'(svtt_pkg::PCT)) >> svtt_pkg::Q_SH);
        pri_q <= 32'((36'(uset_q) * 36'(vt_q)) / 36'(svtt_pkg::USET_FULL));
        if (mode_q == svtt_pkg::BEH_ON && blk_s_q)
          beh_q <= svtt_pkg::BEH_BLOCKED;
        else if (mode_q == svtt_pkg::BEH_TEST && blk_s_q)
          beh_q <= svtt_pkg::BEH_TESTBLK;
        else
          beh_q <= mode_q;
        if (!off && pick_q && blk_s_q && !blocked_q) begin
          evt_q <= 1'b1;
          bvolt_q <= measured_voltage_i;
          bunder_q <= under_q;
          bts_q <= ts_q;
        end
      end
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign start_o = start_q;
  assign trip_o = trip_q;
  assign blocked_o = blocked_q;
  assign blk_evt_o = evt_q;
  assign hmi_note_o = evt_q;
  assign blk_evt_volt_o = bvolt_q;
  assign blk_evt_under_o = bunder_q;
  assign blk_evt_ts_o = bts_q;
endmodule
`default_nettype wire

// ==== testbench/svtt_stage_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module svtt_stage_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // stage
  input wire logic block_i,
  input wire logic start_o,
  input wire logic trip_o,
  input wire logic blocked_o,
  input wire logic blk_evt_o,
  input wire logic hmi_note_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_resp_a: assert property (wb_req |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  rst_clear_a: assert property ($fell(rst_i) |-> !start_o && !trip_o && !blocked_o)
    else $error("outputs set after reset");
  start_cause_a: assert property ($rose(start_o) |-> !$past(block_i, 2))
    else $error("start while blocked");
  blk_cause_a: assert property ($rose(blocked_o) |-> $past(block_i, 2))
    else $error("blocked without block");
  start_excl_a: assert property (!(start_o && blocked_o))
    else $error("start and blocked");
  trip_start_a: assert property ($rose(trip_o) |-> start_o)
    else $error("trip without start");
  evt_note_a: assert property (blk_evt_o |-> hmi_note_o)
    else $error("no display note");
  evt_pulse_a: assert property (blk_evt_o |=> !blk_evt_o)
    else $error("event too long");
endmodule
bind svtt_seq_voltage_stage svtt_stage_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .block_i(block_i),
  .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .blk_evt_o(blk_evt_o),
  .hmi_note_o(hmi_note_o));
`default_nettype wire

// ==== testbench/svtt_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module svtt_far_model (
  // clock
  input wire logic clk_i,
  // bench settings
  input wire logic [15:0] level_i,
  input wire logic hold_i,
  // stage side
  output logic [15:0] volt_o,
  output logic [15:0] line_o,
  output logic blk_o
);
  always_ff @(posedge clk_i) begin
    volt_o <= level_i;
    line_o <= level_i;
  end
  // dedicated block line, registered copy of hold_i, set after the trip
  always_ff @(posedge clk_i) begin
    blk_o <= hold_i;
  end
endmodule
`default_nettype wire

// ==== testbench/tb_svtt_seq_voltage_stage.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_svtt_seq_voltage_stage;
  localparam int C = 200;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd_o;
  logic [15:0] lvl = 16'h2328;
  logic hold = 1'b0;
  logic [15:0] vm;
  logic [15:0] vl;
  logic blk, ack, st, tr, bk, ev;
  wire logic [2:0] outs = {bk, tr, st};
  int n_errors = 0;
  int checked = 0;
  int n_evt = 0;
  int n;
  logic [15:0] ev_volt;
  logic ev_under;
  logic [31:0] ev_ts;
  int n_cyc = 0;
  int ts_exp = 0;
  initial forever #25 clk_i = ~clk_i;
  svtt_far_model far_u (.clk_i(clk_i), .level_i(lvl), .hold_i(hold), .volt_o(vm),
    .line_o(vl), .blk_o(blk));
  svtt_seq_voltage_stage #(.TICK_CYC(C)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack), .measured_voltage_i(vm),
    .line_min_voltage_i(vl), .block_i(blk), .start_o(st), .trip_o(tr), .blocked_o(bk),
    .blk_evt_o(ev), .hmi_note_o(), .blk_evt_volt_o(ev_volt), .blk_evt_under_o(ev_under),
    .blk_evt_ts_o(ev_ts));
  // evaluations fall 202 clocks after reset release, then once per tick
  always @(posedge clk_i) begin
    n_cyc <= rst_i ? 0 : n_cyc + 1;
    if (ev === 1'b1) begin
      n_evt <= n_evt + 1;
      ts_exp <= (n_cyc - 202) / C;
    end
  end
  task stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      stop_test();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask
  task wt(input int w, input logic v, output int k);
    k = 0;
    while (outs[w] !== v && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 2000) begin
      n_errors++;
      stop_test();
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(svtt_pkg::ADR_CTRL, '1, 32'h0000011A, "ctrl");
    rd(svtt_pkg::ADR_DT, '1, 32'h00000008, "dt");
    rd(svtt_pkg::ADR_STAT, 32'h700, 32'h100, "beh_on");
    rd(8'h3C, '1, 32'h0, "unmapped");
    wb(1'b1, svtt_pkg::ADR_DT, 32'h2);
    @(posedge clk_i) lvl <= 16'h2AF8;
    wt(0, 1'b1, n);
    wt(1, 1'b1, n);
    chk("trip_delay", C, n);
    rd(svtt_pkg::ADR_PRI, '1, 32'h0000041A, "pri");
    rd(svtt_pkg::ADR_EXP, '1, 32'h2, "exp");
    rd(svtt_pkg::ADR_STAT, 32'h7, 32'h3, "stat");
    @(posedge clk_i) hold <= 1'b1;
    wt(0, 1'b0, n);
    wt(2, 1'b1, n);
    chk("start_off", 32'h0, st);
    rd(svtt_pkg::ADR_BEVT, 32'h1FFFF, 32'h2AF8, "evt_volt");
    chk("evt_count", 32'h1, n_evt);
    chk("evt_volt_pin", 32'h2AF8, ev_volt);
    chk("evt_under_pin", 32'h0, ev_under);
    chk("evt_ts_pin", ts_exp, ev_ts);
    rd(svtt_pkg::ADR_STAT, 32'h700, 32'h200, "beh_blk");
    lvl <= 16'h2328;
    hold <= 1'b0;
    repeat (20 * C) @(posedge clk_i);
    wb(1'b1, svtt_pkg::ADR_DT, 32'h0);
    @(posedge clk_i) lvl <= 16'h2AF8;
    wt(0, 1'b1, n);
    chk("instant", 32'h1, tr);
    wb(1'b1, svtt_pkg::ADR_CTRL, 32'h0000031C);
    repeat (2 * C) @(posedge clk_i);
    rd(svtt_pkg::ADR_EXP, '1, 32'h000000D2, "exp_inv");
    rd(svtt_pkg::ADR_RATIO, '1, 32'h00000068, "ratio");
    rd(svtt_pkg::ADR_STAT, 32'h700, 32'h300, "beh_test");
    wb(1'b1, svtt_pkg::ADR_CTRL, 32'h0000051A);
    repeat (3 * C) @(posedge clk_i);
    chk("off_start", 32'h0, st);
    rd(svtt_pkg::ADR_STAT, 32'h700, 32'h500, "beh_off");
    stop_test();
  end
endmodule
`default_nettype wire
